// file: logic/udi_irq_ctrl.v
// Interrupt status, gating and host read port of the USB device
//
// Notes on behaviour
// R1: Endpoints 14..1 flag in bits 23..10
// R2: Control IN endpoint flags bit 9
// R3: Control OUT endpoint flags bit 8
// R4: Bit 7 mirrors live suspend, never latches
// R5: Pseudo frame event sets bit 5
// R6: Detected frame start sets bit 4
// R7: DMA counter reaching zero sets bit 3
// R8: Awake to suspend change sets bit 2
// R9: Resume signalling sets bit 1
// R10: Bus reset sets bit 0
// R11: Events always latch; enables gate the output
// R12: Global enable off keeps output inactive
// R13: Polarity and pulse select; reset low, level
// R14: Pulse mode: 166 ns per rising OR; code gives 41 clocks of 4 ns, 164 ns
// R15: Status read clears reset, resume, DMA, frame
// R16: Endpoint flags clear on endpoint status read
// R17: SETUP/OUT interrupt only after data acknowledged
// R18: Bulk interrupts on every ACK exchanged
// R19: Isochronous interrupts on every transaction
// R20: Missing frames give pseudo events every 1 ms
// R21: Three missed frames enter suspend
// R22: Host sends code c0, reads four bytes
// R23: Level output holds while enabled flags set
`timescale 1ns/1ns
`include "udi_irq_defs.vh"
module udi_irq_ctrl #(
    parameter FRAME_CYCLES = `UDI_FRAME_CYCLES,
    parameter EP_COUNT = `UDI_EP_COUNT
) (
    input wire mclk,
    input wire resetn,
    input wire host_cs_n,
    input wire host_rd_n,
    input wire host_wr_n,
    input wire host_a0,
    input wire [7:0] host_data_in,
    output reg [7:0] host_data_out,
    output reg host_data_oe,
    input wire [EP_COUNT-1:0] ep_txn_done,
    input wire [EP_COUNT-1:0] ep_handshake_ack,
    input wire [EP_COUNT-1:0] ep_iso_mode,
    input wire [EP_COUNT-1:0] ep_status_read,
    input wire bus_suspend_in,
    input wire frame_start_seen,
    input wire dma_count_zero,
    input wire resume_seen,
    input wire bus_reset_seen,
    input wire [31:0] irq_enable_mask,
    input wire global_irq_enable,
    input wire irq_polarity_select,
    input wire irq_pulse_level_select,
    input wire pseudo_frame_irq_enable,
    output reg irq_out,
    output reg live_bus_suspend_state
);
    // Pulse length in clocks, cut to the width of its counter
    localparam integer PULSE_CYCLES_I = `UDI_PULSE_CYCLES;
    localparam [5:0] PULSE_LEN = PULSE_CYCLES_I[5:0];

    // Host port state machine
    localparam [1:0] HP_IDLE = 2'h0;
    localparam [1:0] HP_READ = 2'h1;

    wire cs_n_s;
    wire rd_n_s;
    wire wr_n_s;
    wire a0_s;
    wire [7:0] din_s;
    wire pseudo_frame_pulse;
    wire missed_suspend;

    reg rd_n_d_reg;
    reg wr_n_d_reg;
    reg [1:0] hp_state_reg;
    reg [1:0] hp_state_next;
    reg [2:0] byte_idx_reg;
    reg [31:0] snap_reg;
    reg status_read_pulse;
    reg [EP_COUNT-1:0] endpoint_event_flags;
    reg suspend_prev_reg;
    reg pseudo_frame_flag;
    reg frame_flag;
    reg dma_done_flag;
    reg suspend_entry_flag;
    reg resume_flag;
    reg reset_flag;
    reg any_prev_reg;
    reg [5:0] pulse_cnt_reg;
    reg irq_active;

    wire [EP_COUNT-1:0] ep_event;
    wire [31:0] status_word;
    wire [31:0] gate_mask;
    wire any_irq;
    wire rd_fall;
    wire wr_rise;
    wire suspend_now;

    // ****************************************
    // Pin synchronisers
    // ****************************************
    udi_sync #(
        .W(4),
        .RST_VAL(4'hf)
    ) u_sync_ctl (
        .mclk(mclk),
        .resetn(resetn),
        .async_in({host_cs_n, host_rd_n, host_wr_n, host_a0}),
        .sync_out({cs_n_s, rd_n_s, wr_n_s, a0_s})
    );

    udi_sync #(
        .W(8),
        .RST_VAL(8'h00)
    ) u_sync_data (
        .mclk(mclk),
        .resetn(resetn),
        .async_in(host_data_in),
        .sync_out(din_s)
    );

    // ****************************************
    // Pseudo frame timer
    // ****************************************
    udi_frame_timer #(
        .FRAME_CYCLES(FRAME_CYCLES)
    ) u_frame_timer (
        .mclk(mclk),
        .resetn(resetn),
        .frame_seen(frame_start_seen),
        .bus_reset_seen(bus_reset_seen),
        .pseudo_frame_pulse(pseudo_frame_pulse),
        .missed_suspend(missed_suspend)
    );

    // ****************************************
    // Host command port
    // ****************************************
    // Strobe edges, seen only on synchronised levels
    assign rd_fall = rd_n_d_reg & ~rd_n_s & ~cs_n_s;
    assign wr_rise = ~wr_n_d_reg & wr_n_s & ~cs_n_s;

    always @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            rd_n_d_reg <= 1'b1;
            wr_n_d_reg <= 1'b1;
        end else begin
            rd_n_d_reg <= rd_n_s;
            wr_n_d_reg <= wr_n_s;
        end
    end

    // Any command write ends a read sequence; a c0 code starts one
    always @* begin
        hp_state_next = hp_state_reg;
        status_read_pulse = 1'b0;
        case (hp_state_reg)
            HP_IDLE: begin
                if (wr_rise && a0_s && din_s == `UDI_CMD_READ_IRQ) begin
                    hp_state_next = HP_READ;
                    status_read_pulse = 1'b1; // R22
                end
            end
            HP_READ: begin
                if (wr_rise) begin
                    hp_state_next = HP_IDLE;
                    if (a0_s && din_s == `UDI_CMD_READ_IRQ) begin
                        hp_state_next = HP_READ;
                        status_read_pulse = 1'b1;
                    end
                end else if (rd_fall && byte_idx_reg == `UDI_IRQ_BYTES - 3'h1) begin
                    hp_state_next = HP_IDLE;
                end
            end
            default: begin
                hp_state_next = HP_IDLE;
            end
        endcase
    end

    // Snapshot taken with the command, bytes returned low first
    always @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            hp_state_reg <= HP_IDLE;
            byte_idx_reg <= 3'h0;
            snap_reg <= `UDI_STATUS_RST;
            host_data_out <= 8'h00;
            host_data_oe <= 1'b0;
        end else begin
            hp_state_reg <= hp_state_next;
            if (status_read_pulse) begin
                snap_reg <= status_word;
                byte_idx_reg <= 3'h0;
            end else if (rd_fall && hp_state_reg == HP_READ) begin
                byte_idx_reg <= byte_idx_reg + 3'h1;
            end
            if (rd_fall && hp_state_reg == HP_READ) begin
                host_data_out <= snap_reg[{byte_idx_reg[1:0], 3'h0} +: 8];
                host_data_oe <= 1'b1;
            end else if (rd_n_s || cs_n_s) begin
                host_data_oe <= 1'b0;
            end
        end
    end

    // ****************************************
    // Endpoint event qualification
    // ****************************************
    // Non-iso: after ACK; iso: every transaction
    assign ep_event = ep_txn_done & (ep_iso_mode | ep_handshake_ack); // R17 R18 R19

    // One sticky flag per endpoint; event wins over clear
    genvar e;
    generate
        for (e = 0; e < EP_COUNT; e = e + 1) begin : g_ep
            always @(posedge mclk or negedge resetn) begin
                if (!resetn) begin
                    endpoint_event_flags[e] <= 1'b0;
                end else begin
                    endpoint_event_flags[e] <= (endpoint_event_flags[e] & ~ep_status_read[e])
                        | ep_event[e]; // R1 R2 R3 R16
                end
            end
        end
    endgenerate

    // ****************************************
    // Bus event flags
    // ****************************************
    assign suspend_now = bus_suspend_in | missed_suspend; // R21

    // Status read clears these; a same-cycle event still sets
    always @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            suspend_prev_reg <= 1'b0;
            live_bus_suspend_state <= 1'b0;
            pseudo_frame_flag <= 1'b0;
            frame_flag <= 1'b0;
            dma_done_flag <= 1'b0;
            suspend_entry_flag <= 1'b0;
            resume_flag <= 1'b0;
            reset_flag <= 1'b0;
        end else begin
            suspend_prev_reg <= suspend_now;
            live_bus_suspend_state <= suspend_now; // R4
            pseudo_frame_flag <= (pseudo_frame_flag & ~status_read_pulse)
                | pseudo_frame_pulse; // R5
            frame_flag <= (frame_flag & ~status_read_pulse) | frame_start_seen; // R6 R15
            dma_done_flag <= (dma_done_flag & ~status_read_pulse) | dma_count_zero; // R7 R15
            suspend_entry_flag <= (suspend_entry_flag & ~status_read_pulse)
                | (suspend_now & ~suspend_prev_reg); // R8
            resume_flag <= (resume_flag & ~status_read_pulse) | resume_seen; // R9 R15
            reset_flag <= (reset_flag & ~status_read_pulse) | bus_reset_seen; // R10 R15
        end
    end

    // ****************************************
    // Status word and gating
    // ****************************************
    assign status_word = {8'h00, endpoint_event_flags, live_bus_suspend_state, 1'b0,
        pseudo_frame_flag, frame_flag, dma_done_flag, suspend_entry_flag,
        resume_flag, reset_flag};

    // Pseudo frame bit uses its own enable; live state never interrupts
    assign gate_mask = {irq_enable_mask[31:6], pseudo_frame_irq_enable,
        irq_enable_mask[4:0]} & ~(32'h1 << `UDI_BIT_LIVE_SUSPEND);

    assign any_irq = global_irq_enable & (|(status_word & gate_mask)); // R11 R12

    // ****************************************
    // Interrupt output
    // ****************************************
    // Level mode follows the gated OR; pulse mode fires on its rise
    always @* begin
        if (irq_pulse_level_select) begin
            irq_active = (pulse_cnt_reg != 6'h00); // R14
        end else begin
            irq_active = any_irq; // R23
        end
    end

    // Pulse counter reloads on each rise of the gated OR
    always @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            any_prev_reg <= 1'b0;
            pulse_cnt_reg <= 6'h00;
            irq_out <= `UDI_PIN_RST_HIGH;
        end else begin
            any_prev_reg <= any_irq;
            if (any_irq && !any_prev_reg) begin
                pulse_cnt_reg <= PULSE_LEN; // R14
            end else if (pulse_cnt_reg != 6'h00) begin
                pulse_cnt_reg <= pulse_cnt_reg - 6'h01;
            end
            // Polarity select low means active low
            irq_out <= irq_polarity_select ? irq_active : ~irq_active; // R13
        end
    end
endmodule

// file: inc/udi_irq_defs.vh
// Constants for the USB device interrupt logic
`ifndef UDI_IRQ_DEFS_VH
`define UDI_IRQ_DEFS_VH

// ****************************************
// Host command codes and transfer size
// ****************************************
`define UDI_CMD_READ_IRQ 8'hc0
`define UDI_IRQ_BYTES 3'h4

// ****************************************
// Status word field positions
// ****************************************
`define UDI_BIT_BUS_RESET 0
`define UDI_BIT_RESUME 1
`define UDI_BIT_SUSPEND_ENTRY 2
`define UDI_BIT_DMA_DONE 3
`define UDI_BIT_FRAME 4
`define UDI_BIT_PSEUDO_FRAME 5
`define UDI_BIT_LIVE_SUSPEND 7
`define UDI_BIT_CTRL_OUT 8
`define UDI_BIT_CTRL_IN 9
`define UDI_EP_LSB 8
`define UDI_EP_MSB 23
`define UDI_EP_COUNT 16

// ****************************************
// Reset values
// ****************************************
`define UDI_STATUS_RST 32'h0000_0000
`define UDI_PIN_RST_HIGH 1'b1

// ****************************************
// Timing
// ****************************************
`define UDI_CLK_PERIOD_NS 4
`define UDI_PULSE_NS 166
`define UDI_PULSE_CYCLES (`UDI_PULSE_NS / `UDI_CLK_PERIOD_NS)
`define UDI_FRAME_US 1000
`define UDI_FRAME_CYCLES ((`UDI_FRAME_US * 1000) / `UDI_CLK_PERIOD_NS)
`define UDI_MISSED_FRAMES_SUSPEND 2'h3

`endif

// file: logic/udi_sync.v
// Two-flop synchroniser for pin inputs
`timescale 1ns/1ns
module udi_sync #(
    parameter W = 1,
    parameter [W-1:0] RST_VAL = {W{1'b0}}
) (
    input wire mclk,
    input wire resetn,
    input wire [W-1:0] async_in,
    output wire [W-1:0] sync_out
);
    // ****************************************
    // One synchroniser per bit
    // ****************************************
    genvar i;
    generate
        for (i = 0; i < W; i = i + 1) begin : g_bit
            reg meta_reg;
            reg stable_reg;
            // First flop feeds only the second
            always @(posedge mclk or negedge resetn) begin
                if (!resetn) begin
                    meta_reg <= RST_VAL[i];
                    stable_reg <= RST_VAL[i];
                end else begin
                    meta_reg <= async_in[i];
                    stable_reg <= meta_reg;
                end
            end
            assign sync_out[i] = stable_reg;
        end
    endgenerate
endmodule

// file: logic/udi_frame_timer.v
// Pseudo frame timer and missed-frame suspend detector
`timescale 1ns/1ns
`include "udi_irq_defs.vh"
module udi_frame_timer #(
    parameter FRAME_CYCLES = `UDI_FRAME_CYCLES
) (
    input wire mclk,
    input wire resetn,
    input wire frame_seen,
    input wire bus_reset_seen,
    output reg pseudo_frame_pulse,
    output reg missed_suspend
);
    reg [19:0] count_reg;
    reg [1:0] missed_reg;
    reg armed_reg;

    // ****************************************
    // Frame interval counter
    // ****************************************
    // Timer arms on the first real frame and restarts on every one
    always @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            count_reg <= 20'h0_0000;
            missed_reg <= 2'h0;
            armed_reg <= 1'b0;
            pseudo_frame_pulse <= 1'b0;
            missed_suspend <= 1'b0;
        end else begin
            pseudo_frame_pulse <= 1'b0;
            if (bus_reset_seen) begin
                count_reg <= 20'h0_0000;
                missed_reg <= 2'h0;
                armed_reg <= 1'b0;
                missed_suspend <= 1'b0;
            end else if (frame_seen) begin
                count_reg <= 20'h0_0000;
                missed_reg <= 2'h0;
                armed_reg <= 1'b1;
                missed_suspend <= 1'b0;
            end else if (armed_reg && !missed_suspend) begin
                if (count_reg == FRAME_CYCLES[19:0] - 20'h0_0001) begin
                    count_reg <= 20'h0_0000;
                    pseudo_frame_pulse <= 1'b1; // R20
                    missed_reg <= missed_reg + 2'h1;
                    if (missed_reg + 2'h1 == `UDI_MISSED_FRAMES_SUSPEND) begin
                        missed_suspend <= 1'b1; // R21
                    end
                end else begin
                    count_reg <= count_reg + 20'h0_0001;
                end
            end
        end
    end
endmodule

// file: tb/udi_irq_props.sv
// Checker of the interrupt output and host port timing
`timescale 1ns/1ns
`include "udi_irq_defs.vh"
module udi_irq_props #(
    parameter FRAME_CYCLES = 100,
    parameter EP_COUNT = 16
) (
    input wire mclk,
    input wire resetn,
    input wire host_cs_n,
    input wire host_rd_n,
    input wire [7:0] host_data_out,
    input wire host_data_oe,
    input wire [EP_COUNT-1:0] ep_txn_done,
    input wire [EP_COUNT-1:0] ep_handshake_ack,
    input wire [EP_COUNT-1:0] ep_iso_mode,
    input wire bus_suspend_in,
    input wire dma_count_zero,
    input wire bus_reset_seen,
    input wire [31:0] irq_enable_mask,
    input wire global_irq_enable,
    input wire irq_polarity_select,
    input wire irq_pulse_level_select,
    input wire irq_out,
    input wire live_bus_suspend_state
);
    // ****************************************
    // Helper logic and properties
    // ****************************************
    localparam int PULSE_LEN = `UDI_PULSE_CYCLES;
    reg [7:0] act_reg;
    wire lvl = global_irq_enable && !irq_pulse_level_select;
    wire [15:0] ep_hit = ep_txn_done & (ep_handshake_ack | ep_iso_mode) & irq_enable_mask[23:8];
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!resetn);
    // Counts consecutive active cycles of the output
    always @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            act_reg <= 8'h00;
        end else begin
            act_reg <= (irq_out == irq_polarity_select) ? act_reg + 8'h01 : 8'h00;
        end
    end
    a_bus_reset_irq: assert property (
        bus_reset_seen && irq_enable_mask[0] && lvl && !irq_polarity_select
        ##1 lvl && !irq_polarity_select |=> !irq_out) else $error("bus reset gave no irq");
    a_dma_irq_high: assert property (
        dma_count_zero && irq_enable_mask[3] && lvl && irq_polarity_select
        ##1 lvl && irq_polarity_select |=> irq_out) else $error("dma done gave no irq");
    a_endpoint_irq: assert property (
        (|ep_hit) && lvl && !irq_polarity_select
        ##1 lvl && !irq_polarity_select |=> !irq_out) else $error("endpoint gave no irq");
    a_global_off_quiet: assert property (
        !$past(global_irq_enable) && !global_irq_enable && !irq_pulse_level_select
        && $stable(irq_polarity_select) |-> irq_out == !irq_polarity_select)
        else $error("irq active while globally off");
    a_pulse_width: assert property (
        irq_pulse_level_select && $stable(irq_polarity_select)
        && $past(irq_out) == irq_polarity_select && irq_out != irq_polarity_select
        |-> act_reg == PULSE_LEN) else $error("pulse width wrong");
    a_pulse_not_long: assert property (
        irq_pulse_level_select |-> act_reg <= PULSE_LEN) else $error("pulse too long");
    a_live_suspend: assert property (
        bus_suspend_in |-> ##[1:2] live_bus_suspend_state) else $error("suspend not mirrored");
    a_oe_needs_read: assert property (
        host_data_oe |-> !$past(host_rd_n, 3) && !$past(host_cs_n, 3))
        else $error("data driven without read");
    a_oe_release: assert property (
        $rose(host_rd_n) |-> ##[1:3] !host_data_oe) else $error("data bus not released");
    a_data_holds: assert property (
        $fell(host_data_oe) |-> $stable(host_data_out)) else $error("read byte changed");
endmodule

bind udi_irq_ctrl udi_irq_props #(.FRAME_CYCLES(FRAME_CYCLES), .EP_COUNT(EP_COUNT))
    u_udi_irq_props (
    .mclk(mclk), .resetn(resetn), .host_cs_n(host_cs_n), .host_rd_n(host_rd_n),
    .host_data_out(host_data_out), .host_data_oe(host_data_oe), .ep_txn_done(ep_txn_done),
    .ep_handshake_ack(ep_handshake_ack), .ep_iso_mode(ep_iso_mode),
    .bus_suspend_in(bus_suspend_in), .dma_count_zero(dma_count_zero),
    .bus_reset_seen(bus_reset_seen), .irq_enable_mask(irq_enable_mask),
    .global_irq_enable(global_irq_enable), .irq_polarity_select(irq_polarity_select),
    .irq_pulse_level_select(irq_pulse_level_select), .irq_out(irq_out),
    .live_bus_suspend_state(live_bus_suspend_state));

// file: tb/udi_host_model.sv
// Host microcontroller model on the parallel command port
`timescale 1ns/1ns
`include "udi_irq_defs.vh"
module udi_host_model (
    input wire mclk,
    output reg host_cs_n,
    output reg host_rd_n,
    output reg host_wr_n,
    output reg host_a0,
    output reg [7:0] host_data_in,
    input wire [7:0] host_data_out,
    input wire host_data_oe
);
    // ****************************************
    // Strobe sequences
    // ****************************************
    // Idle pins
    initial begin
        host_cs_n = 1'b1;
        host_rd_n = 1'b1;
        host_wr_n = 1'b1;
        host_a0 = 1'b1;
        host_data_in = 8'h00;
    end
    // Strobes stay put for three clocks on each side
    task automatic hold3;
        repeat (3) @(posedge mclk);
        #1;
    endtask
    // Command phase, taken on the write strobe rise
    task automatic command(input [7:0] code);
        host_a0 = 1'b1;
        host_cs_n = 1'b0;
        host_data_in = code;
        hold3();
        host_wr_n = 1'b0;
        hold3();
        host_wr_n = 1'b1;
        hold3();
        host_data_in = ~code; // Released bus shows no stale value
        host_a0 = 1'b0;
    endtask
    // One data byte; ok stays low if the device never drives
    task automatic read_byte(output [7:0] b, output ok);
        int n;
        ok = 1'b0;
        hold3();
        host_rd_n = 1'b0;
        for (n = 0; n < 8 && !ok; n++) begin
            @(posedge mclk);
            #1;
            ok = (host_data_oe === 1'b1);
        end
        b = ok ? host_data_out : 8'hxx;
        host_rd_n = 1'b1;
        host_data_in = ~host_data_in;
    endtask
    // Status fetch: code then all four bytes, low byte first
    task automatic read_status(output [31:0] w);
        logic ok;
        logic [7:0] b;
        int i;
        command(`UDI_CMD_READ_IRQ);
        for (i = 0; i < `UDI_IRQ_BYTES; i++) begin
            read_byte(b, ok);
            w[8*i +: 8] = b;
        end
    endtask
    // Deselect the device
    task automatic release_bus;
        hold3();
        host_cs_n = 1'b1;
        hold3();
    endtask
endmodule

// file: tb/udi_irq_ctrl_bench.sv
// Self-checking bench of the interrupt status and output logic
`timescale 1ns/1ns
`include "udi_irq_defs.vh"
module udi_irq_ctrl_bench;
    // ****************************************
    // Stimulus and scenarios
    // ****************************************
    localparam int FRAMES = 100;
    reg mclk = 1'b0;
    reg resetn = 1'b0;
    wire cs_n, rd_n, wr_n, a0, oe, irq, live;
    wire [7:0] din;
    wire [7:0] dout;
    reg [15:0] txn = 16'h0000;
    reg [15:0] ack = 16'h0000;
    reg [15:0] iso = 16'h0000;
    reg [15:0] epr = 16'h0000;
    reg [3:0] evt = 4'h0; // Frame, dma, resume, bus reset
    reg [31:0] mask = 32'h0000_0000;
    reg susp = 1'b0, gen = 1'b0, pol = 1'b0, pmode = 1'b0, pfen = 1'b0;
    reg [31:0] w;
    reg [7:0] b;
    reg ok;
    int fails = 0;
    int total_checks = 0;
    int n;
    always #2 mclk = ~mclk;
    udi_host_model u_udi_host_model (.mclk(mclk), .host_cs_n(cs_n), .host_rd_n(rd_n),
        .host_wr_n(wr_n), .host_a0(a0), .host_data_in(din), .host_data_out(dout),
        .host_data_oe(oe));
    udi_irq_ctrl #(.FRAME_CYCLES(FRAMES)) u_udi_irq_ctrl (.mclk(mclk), .resetn(resetn),
        .host_cs_n(cs_n), .host_rd_n(rd_n), .host_wr_n(wr_n), .host_a0(a0),
        .host_data_in(din), .host_data_out(dout), .host_data_oe(oe), .ep_txn_done(txn),
        .ep_handshake_ack(ack), .ep_iso_mode(iso), .ep_status_read(epr),
        .bus_suspend_in(susp), .frame_start_seen(evt[3]), .dma_count_zero(evt[2]),
        .resume_seen(evt[1]), .bus_reset_seen(evt[0]), .irq_enable_mask(mask),
        .global_irq_enable(gen), .irq_polarity_select(pol), .irq_pulse_level_select(pmode),
        .pseudo_frame_irq_enable(pfen), .irq_out(irq), .live_bus_suspend_state(live));
    task automatic check(input string name, input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            fails++;
            $display("Error %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic cyc(input int k);
        repeat (k) @(posedge mclk);
        #1;
    endtask
    task automatic ev(input [3:0] v);
        evt = v;
        cyc(1);
        evt = 4'h0;
        cyc(1); // Gap so back-to-back events never share a time step
    endtask
    task automatic rd;
        u_udi_host_model.read_status(w);
        u_udi_host_model.release_bus();
    endtask
    task automatic t_reset;
        check("irq idle", irq, 1'b1);
        check("live idle", live, 1'b0);
        u_udi_host_model.read_status(w);
        u_udi_host_model.read_byte(b, ok);
        u_udi_host_model.release_bus();
        check("status reset", w, `UDI_STATUS_RST);
        check("fifth byte", ok, 1'b0);
    endtask
    task automatic t_endpoints;
        mask = 32'hffff_ffff;
        gen = 1'b1;
        {txn, ack, iso} = {16'hffff, 16'h00ff, 16'h0f00};
        cyc(1);
        {txn, ack, iso} = 48'h0;
        cyc(2);
        check("ep irq", irq, 1'b0);
        rd();
        check("ep flags", w, 32'h000f_ff00);
        rd();
        check("ep flags kept", w, 32'h000f_ff00);
        epr = 16'h0001;
        cyc(1);
        epr = 16'h0000;
        rd();
        check("ep out cleared", w, 32'h000f_fe00);
        epr = 16'hfffe;
        cyc(1);
        epr = 16'h0000;
        cyc(2);
        check("ep irq gone", irq, 1'b1);
    endtask
    task automatic t_gating;
        gen = 1'b0;
        pol = 1'b1;
        ev(4'h4);
        cyc(3);
        check("global off", irq, 1'b0);
        gen = 1'b1;
        cyc(3);
        check("global on", irq, 1'b1);
        rd();
        cyc(2);
        check("cleared", irq, 1'b0);
        ev(4'h4);
        cyc(2);
        check("dma high", irq, 1'b1);
        pol = 1'b0;
        cyc(2);
        check("dma low", irq, 1'b0);
        rd();
        check("dma flag", w, 32'h0000_0008);
    endtask
    task automatic t_pulse;
        pmode = 1'b1;
        mask = 32'h0000_0001;
        cyc(3);
        ev(4'h1);
        n = 0;
        repeat (60) begin
            cyc(1);
            n += (irq === 1'b0);
        end
        check("pulse cycles", n, `UDI_PULSE_CYCLES);
        rd();
        check("reset flag", w, 32'h0000_0001);
        pmode = 1'b0;
    endtask
    task automatic t_flags;
        ev(4'h1);
        cyc(1);
        check("level irq", irq, 1'b0);
        ev(4'h2);
        ev(4'h4);
        susp = 1'b1;
        cyc(2);
        ev(4'h8);
        check("live on", live, 1'b1);
        rd();
        check("events", w, 32'h0000_009f);
        rd();
        check("read clears", w, 32'h0000_0080);
        susp = 1'b0;
        mask = 32'h0000_0000;
        pfen = 1'b1;
        ev(4'h8);
        cyc(FRAMES + 5);
        check("pseudo irq", irq, 1'b0);
        check("one miss", live, 1'b0);
        cyc(FRAMES * 2);
        check("third miss", live, 1'b1);
        rd();
        check("pseudo flags", w & 32'hffff_fffb, 32'h0000_00b0);
        ev(4'h8);
        cyc(2);
        check("frame wakes", live, 1'b0);
    endtask
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    // Main sequence after a four-cycle reset
    initial begin
        repeat (4) @(posedge mclk);
        #1;
        resetn = 1'b1;
        cyc(2);
        t_reset();
        t_endpoints();
        t_gating();
        t_pulse();
        t_flags();
        tally_and_finish();
    end
    // Watchdog against a hang
    initial begin
        #100000;
        fails++;
        tally_and_finish();
    end
endmodule
